// File: include/scl_regs.vh
// constants for the single contact link bit codec (master side)
// assumes a 25 MHz system clock; no software registers
// Behaviour
// - a sent one stays high 0.70 to 0.80 of the period, nominally 0.75.
// - a sent zero stays high 0.20 to 0.30 of the period, nominally 0.25.
// - the transmitter sends bits back to back with no gap.
// - rising edges of the voltage signal bound each bit period.
// - period may change per bit; each bit is measured on its own.
// - period 1 to 5 us by default, 0.6 to 10 us when extended.
// - return current 600 to 1000 uA reads high, 0 to 20 uA reads low.
// - voltage carries master data, current carries slave data, both at once.
// - the return signal is valid only while the voltage signal is high.
`ifndef SCL_REGS_VH
`define SCL_REGS_VH
`define SCL_CLK_MHZ       25
`define SCL_PER_W         9
`define SCL_PER_DEF       9'h032
`define SCL_PER_MIN_DEF   9'h019
`define SCL_PER_MAX_DEF   9'h07D
`define SCL_PER_MIN_EXT   9'h00F
`define SCL_PER_MAX_EXT   9'h0FA
`define SCL_ONE_NUM       3
`define SCL_ROUND_ADD     2'h2
`define SCL_QUART_SHIFT   2
`define SCL_SMP_SHIFT     1
`endif

// File: rtl/scl_bit_codec.v
// master bit codec: drives the voltage signal, samples the return current level
// assumes an analog front end turns current into a logic level on ret_level
`timescale 1ns/1ps
`include "scl_regs.vh"
module scl_bit_codec #(
	parameter PER_W = `SCL_PER_W
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             rst,
	// configuration
	input  wire [PER_W-1:0] bit_period,
	input  wire             ext_durations,
	// transmit stream
	input  wire             tx_valid,
	output wire             tx_ready,
	input  wire             tx_bit,
	// line
	output reg              master_voltage_signal,
	input  wire             ret_level,
	// receive stream and error flags
	output wire             rx_valid,
	input  wire             rx_ready,
	output wire             rx_bit,
	output reg              rx_overrun_reg,
	output reg              period_err_reg
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	// ==========================================================
	// period check
	function in_range;
		input [PER_W-1:0] p;
		input             ext;
		begin
			if (ext)
				in_range = (p >= `SCL_PER_MIN_EXT) && (p <= `SCL_PER_MAX_EXT);
			else
				in_range = (p >= `SCL_PER_MIN_DEF) && (p <= `SCL_PER_MAX_DEF);
		end
	endfunction

	// ==========================================================
	// transmit sequencer
	reg             state_reg;
	reg [PER_W-1:0] cnt_reg;
	reg [PER_W-1:0] per_reg;
	reg [PER_W-1:0] high_reg;
	wire            per_ok = in_range(bit_period, ext_durations);
	wire            at_end = (cnt_reg == per_reg - {{(PER_W-1){1'b0}}, 1'b1});
	wire            load = (state_reg == ST_IDLE) || at_end;
	// high times rounded to nearest cycle; truncation breaks the ratio at short periods
	wire [PER_W+1:0] p_x = {2'b00, bit_period};
	wire [PER_W+1:0] rnd_x = {{PER_W{1'b0}}, `SCL_ROUND_ADD};
	wire [PER_W+1:0] quart_x = (p_x + rnd_x) >> `SCL_QUART_SHIFT;
	wire [PER_W+1:0] three_x = ((p_x << 1) + p_x + rnd_x) >> `SCL_QUART_SHIFT;
	wire [PER_W-1:0] quart = quart_x[PER_W-1:0];
	// sample point from the latched period, not the live input
	wire [PER_W+1:0] run_x = ({2'b00, per_reg} + rnd_x) >> (`SCL_QUART_SHIFT + `SCL_SMP_SHIFT);
	wire [PER_W-1:0] smp_pt = run_x[PER_W-1:0];
	assign tx_ready = load && per_ok;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= {PER_W{1'b0}};
			per_reg <= `SCL_PER_DEF;
			high_reg <= {PER_W{1'b0}};
			master_voltage_signal <= 1'b0;
			period_err_reg <= 1'b0;
		end else begin
			period_err_reg <= tx_valid && !per_ok;
			if (load) begin
				if (tx_valid && per_ok) begin
					state_reg <= ST_RUN;
					cnt_reg <= {PER_W{1'b0}};
					per_reg <= bit_period;
					high_reg <= tx_bit ? three_x[PER_W-1:0] : quart;
					master_voltage_signal <= 1'b1;
				end else begin
					state_reg <= ST_IDLE;
					master_voltage_signal <= 1'b0;
				end
			end else begin
				cnt_reg <= cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
				if (cnt_reg + {{(PER_W-1){1'b0}}, 1'b1} == high_reg)
					master_voltage_signal <= 1'b0;
			end
		end
	end

	// ==========================================================
	// return current sampling, two flops first
	reg ret_s1_reg;
	reg ret_s2_reg;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ret_s1_reg <= 1'b0;
			ret_s2_reg <= 1'b0;
		end else begin
			ret_s1_reg <= ret_level;
			ret_s2_reg <= ret_s1_reg;
		end
	end
	// sample mid high phase of a zero, where a one is also high
	wire smp_now = (state_reg == ST_RUN) && master_voltage_signal &&
		(cnt_reg == smp_pt);

	// ==========================================================
	// two-entry receive buffer
	reg [1:0] buf_reg;
	reg [1:0] cnt_b_reg;
	reg       wp_reg;
	reg       rp_reg;
	wire      b_full = cnt_b_reg[1];
	wire      b_push = smp_now && !b_full;
	wire      b_pop = rx_valid && rx_ready;
	assign rx_valid = (cnt_b_reg != 2'h0);
	assign rx_bit = buf_reg[rp_reg];
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			buf_reg <= 2'h0;
			cnt_b_reg <= 2'h0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			rx_overrun_reg <= 1'b0;
		end else begin
			if (smp_now && b_full)
				rx_overrun_reg <= 1'b1;
			if (b_push) begin
				buf_reg[wp_reg] <= ret_s2_reg;
				wp_reg <= ~wp_reg;
			end
			if (b_pop)
				rp_reg <= ~rp_reg;
			cnt_b_reg <= cnt_b_reg + {1'b0, b_push} - {1'b0, b_pop};
		end
	end
endmodule

// File: bench/scl_slave_model.sv
// card slave: decodes each bit, answers two bits later
`timescale 1ns/1ps
module scl_slave_model (input wire master_voltage_signal, output reg ret_level);
	realtime rise_t = 0, fall_t = 0;
	reg dec = 0;
	initial ret_level = 0;
	always @(posedge master_voltage_signal) begin
		dec = 2 * (fall_t - rise_t) > $realtime - rise_t;
		rise_t = $realtime;
	end
	always @(negedge master_voltage_signal) begin
		fall_t = $realtime;
		ret_level <= dec;
	end
endmodule

// File: bench/scl_checker.sv
// bit timing checker; sees scl_bit_codec ports only
`timescale 1ns/1ps
module scl_checker #(parameter PER_W = 9) (input wire clk_sys, rst, tx_valid, tx_ready, tx_bit,
	input wire master_voltage_signal, rx_valid, rx_ready, rx_bit, period_err_reg,
	input wire [PER_W-1:0] bit_period);
	reg [9:0] cnt_reg;
	reg [PER_W-1:0] per_reg;
	reg bit_reg;
	// cycles since the last take, saturating while idle
	always @(posedge clk_sys or posedge rst)
		if (rst) {cnt_reg, per_reg, bit_reg} <= {10'h3FF, {PER_W{1'b0}}, 1'b0};
		else if (tx_valid && tx_ready) {cnt_reg, per_reg, bit_reg} <= {10'h001, bit_period, tx_bit};
		else if (cnt_reg != 10'h3FF) cnt_reg <= cnt_reg + 10'h001;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_take; tx_valid && tx_ready; endsequence
	sequence s_fall; $fell(master_voltage_signal); endsequence
	rise_on_take_a: assert property (s_take |=> master_voltage_signal) else $error("no rise");
	one_high_a: assert property (s_fall ##0 bit_reg |-> 10*(cnt_reg-1) >= 7*per_reg && 10*(cnt_reg-1) <= 8*per_reg)
		else $error("bad one");
	zero_high_a: assert property (s_fall ##0 !bit_reg |-> 10*(cnt_reg-1) >= 2*per_reg && 10*(cnt_reg-1) <= 3*per_reg)
		else $error("bad zero");
	take_spacing_a: assert property (s_take |-> cnt_reg >= per_reg) else $error("early take");
	back_to_back_a: assert property (cnt_reg == per_reg && tx_valid |-> tx_ready or ##1 period_err_reg)
		else $error("gap");
	idle_low_a: assert property (cnt_reg > per_reg |-> !master_voltage_signal) else $error("line high");
	refuse_flag_a: assert property (tx_valid && !tx_ready && cnt_reg >= per_reg |=> period_err_reg)
		else $error("no err");
	rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_bit)) else $error("rx lost");
endmodule
bind scl_bit_codec scl_checker #(.PER_W(PER_W)) i_scl_checker (.*);

// File: bench/single_wire_pulse_width_bit_codec_tb.sv
// random stream through the codec, echoed by the slave model
`timescale 1ns/1ps
module single_wire_pulse_width_bit_codec_tb;
	reg clk_sys = 0, rst = 1, ext_durations = 0, tx_valid = 0, tx_bit = 0, rx_ready = 0;
	reg [8:0] bit_period = 9'h032;
	wire tx_ready, master_voltage_signal, ret_level, rx_valid, rx_bit, rx_overrun_reg, period_err_reg;
	integer miscompares = 0, checks = 0, cyc = 0, i;
	reg exp_q[$] = '{0, 0};
	reg [9:0] bad[4] = '{10'h018, 10'h07E, 10'h20E, 10'h2FB};
	scl_bit_codec i_scl_bit_codec (.*);
	scl_slave_model i_scl_slave_model (.*);
	always #20 clk_sys = ~clk_sys;
	task chk(input [9:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %h %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (!rst && rx_valid && rx_ready) chk(rx_bit, exp_q.pop_front());
		if (!rst && tx_valid && tx_ready) exp_q.push_back(tx_bit);
		cyc++;
		if (cyc == 8000) begin
			miscompares++;
			finish_test;
		end
	end
	initial begin
		i = $urandom(84921);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys) rst = 0;
		for (i = 0; i < 4; i++) begin
			@(negedge clk_sys) {ext_durations, bit_period} = bad[i];
			tx_valid = 1;
			@(negedge clk_sys) chk(tx_ready, 0);
			chk(period_err_reg, 1);
		end
		for (i = 0; i < 6000; i++) begin
			@(negedge clk_sys) ext_durations = i >= 3000;
			bit_period = ext_durations ? 9'h00F + $urandom % 236 : 9'h019 + $urandom % 101;
			{tx_bit, rx_ready} = $urandom;
		end
		{tx_valid, rx_ready} = 2'h1;
		repeat (600) @(negedge clk_sys);
		chk(exp_q.size(), 2);
		chk(rx_overrun_reg, 0);
		finish_test;
	end
endmodule
